/* File: common/fpcd_map.vh */
// Constants of the flash protection command host: register offsets,
// field positions, command codes, operation codes and bus timing.
// Assumes includers already run on pclk at 125 MHz.
`ifndef FPCD_MAP_VH
`define FPCD_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------
`define FPCD_OFF_CMD 8'h00
`define FPCD_OFF_ADDR 8'h04
`define FPCD_OFF_WDATA 8'h08
`define FPCD_OFF_STATUS 8'h0c
`define FPCD_OFF_RDATA 8'h10
`define FPCD_OFF_COUNT 8'h14
`define FPCD_OFF_BUF0 8'h20
`define FPCD_OFF_BUF3 8'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPCD_ST_BUSY 0
`define FPCD_ST_REFUSED 1
`define FPCD_ST_MODE_LO 3
`define FPCD_ST_PWNEXT_LO 6
`define FPCD_RD_PROT 16
`define FPCD_LREG_PERSIST_BIT 1
`define FPCD_LREG_PASSWD_BIT 2
`define FPCD_SECTOR_LO 16

// ----------------------------------------------------------------
// Flash command words and unlock addresses
// ----------------------------------------------------------------
`define FPCD_UNLOCK_A1 26'h0000555
`define FPCD_UNLOCK_A2 26'h00002aa
`define FPCD_UNLOCK_D1 16'h00aa
`define FPCD_UNLOCK_D2 16'h0055
`define FPCD_CMD_LOCK_ENT 16'h0050
`define FPCD_CMD_DYB_ENT 16'h00e0
`define FPCD_CMD_ECC_ENT 16'h0075
`define FPCD_CMD_LREG_ENT 16'h0040
`define FPCD_CMD_PWD_ENT 16'h0060
`define FPCD_CMD_PROG 16'h00a0
`define FPCD_CMD_EXIT 16'h0090
`define FPCD_CMD_RESET 16'h00f0
`define FPCD_CMD_BUF_LOAD 16'h0025
`define FPCD_CMD_BUF_CONF 16'h0029
`define FPCD_PROT_STATE 8'h00

// ----------------------------------------------------------------
// Operation codes written to CMD
// ----------------------------------------------------------------
`define FPCD_OP_ARR_RD 5'h00
`define FPCD_OP_LOCK_ENT 5'h01
`define FPCD_OP_LOCK_CLR 5'h02
`define FPCD_OP_LOCK_RD 5'h03
`define FPCD_OP_DYB_ENT 5'h04
`define FPCD_OP_DYB_SET 5'h05
`define FPCD_OP_DYB_CLR 5'h06
`define FPCD_OP_DYB_RD 5'h07
`define FPCD_OP_ECC_ENT 5'h08
`define FPCD_OP_ECC_RD 5'h09
`define FPCD_OP_EXIT 5'h0a
`define FPCD_OP_RESET 5'h0b
`define FPCD_OP_LREG_ENT 5'h0c
`define FPCD_OP_LREG_PRG 5'h0d
`define FPCD_OP_LREG_RD 5'h0e
`define FPCD_OP_PWD_ENT 5'h0f
`define FPCD_OP_PWD_PRG 5'h10
`define FPCD_OP_PWD_RD 5'h11
`define FPCD_OP_BUF_LOAD 5'h12
`define FPCD_OP_ABORT_RST 5'h13

// ----------------------------------------------------------------
// Command modes tracked by the host
// ----------------------------------------------------------------
`define FPCD_MODE_ARRAY 3'h0
`define FPCD_MODE_LOCK 3'h1
`define FPCD_MODE_DYB 3'h2
`define FPCD_MODE_ECC 3'h3
`define FPCD_MODE_LREG 3'h4
`define FPCD_MODE_PWD 3'h5

// ----------------------------------------------------------------
// Bus timing
// ----------------------------------------------------------------
`define FPCD_T_CLK_NS 8
`define FPCD_T_WP_NS 35
`define FPCD_T_ACC_NS 110
`define FPCD_SYNC_CYC 2
`define FPCD_WP_CYC ((`FPCD_T_WP_NS + `FPCD_T_CLK_NS - 1) / `FPCD_T_CLK_NS)
`define FPCD_ACC_CYC ((`FPCD_T_ACC_NS + `FPCD_T_CLK_NS - 1) / `FPCD_T_CLK_NS)
`define FPCD_RD_CYC (`FPCD_ACC_CYC + `FPCD_SYNC_CYC)

`endif

/* File: core/fpcd_sync.v */
// Two-flop synchroniser for pin inputs.
// Assumes the input is asynchronous to pclk; bits are not coherent.
`timescale 1ns/1ps
module fpcd_sync #(
  parameter W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // fpcd_sync

/* File: core/fpcd_cycle.v */
// One asynchronous flash bus cycle: write or read, strobe timing from map.
// Assumes dq_in is already synchronised; read sampling allows for that.
`timescale 1ns/1ps
`include "fpcd_map.vh"
module fpcd_cycle (
  input wire pclk,
  input wire presetn,
  input wire go,
  input wire rd,
  input wire [25:0] a,
  input wire [15:0] d,
  input wire [15:0] dq_in,
  output reg done,
  output reg [15:0] rdata,
  output reg [25:0] fl_addr,
  output reg [15:0] fl_dq_out,
  output reg fl_dq_oe_n,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n
);
  localparam [1:0] C_IDLE = 2'd0;
  localparam [1:0] C_SETUP = 2'd1;
  localparam [1:0] C_PULSE = 2'd2;
  localparam [1:0] C_HOLD = 2'd3;
  localparam integer WP_END = `FPCD_WP_CYC - 1;
  localparam integer RD_END = `FPCD_RD_CYC - 1;
  localparam [4:0] WP_LAST = WP_END[4:0];
  localparam [4:0] RD_LAST = RD_END[4:0];

  reg [1:0] st_q;
  reg [4:0] cnt_q;
  reg rd_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= C_IDLE;
      cnt_q <= 5'h00;
      rd_q <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      fl_addr <= 26'h0000000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_q)
        C_IDLE: begin
          if (go) begin
            fl_addr <= a;
            fl_dq_out <= d;
            rd_q <= rd;
            fl_dq_oe_n <= rd;
            fl_ce_n <= 1'b0;
            st_q <= C_SETUP;
          end
        end
        C_SETUP: begin
          cnt_q <= 5'h00;
          if (rd_q) begin
            fl_oe_n <= 1'b0;
          end else begin
            fl_we_n <= 1'b0;
          end
          st_q <= C_PULSE;
        end
        C_PULSE: begin
          cnt_q <= cnt_q + 5'h01;
          // Read holds oe low long enough to cover access time plus sync delay
          if (rd_q && cnt_q == RD_LAST) begin
            rdata <= dq_in;
            fl_oe_n <= 1'b1;
            st_q <= C_HOLD;
          end else if (!rd_q && cnt_q == WP_LAST) begin
            fl_we_n <= 1'b1;
            st_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          // Data held one cycle past the rising write strobe
          fl_ce_n <= 1'b1;
          fl_dq_oe_n <= 1'b1;
          done <= 1'b1;
          st_q <= C_IDLE;
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end
endmodule // fpcd_cycle

/* File: core/fpcd_host.v */
// Host controller for the protection command sets of a parallel NOR flash.
// Software writes operations over APB; the sequencer issues bus cycles.
// Assumes one pclk domain; flash data pins are asynchronous.
//
// Behaviour
// - Lock set entry 555/AA,2AA/55,555/50; inside, A0 then 0 clears lock bit
// - Volatile overlay entry 555/AA, 2AA/55, 555/E0
// - In volatile overlay A0 then sector write 0 sets, 1 clears bit
// - ECC overlay entry unlock plus 555/75; reads give ECC; F0 leaves
// - After any entry, exit or reset needed before array reads
// - Reset command resumes array reads from identification or limit flag
// - All command cycles are writes except the listed read cycles
// - Buffer abort recovery uses the full three-write reset sequence
// - One password word per A0 command, words 0 to 3 in order
// - Buffer count is locations minus one; all in one line
`timescale 1ns/1ps
`include "fpcd_map.vh"
module fpcd_host (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output wire [25:0] fl_addr,
  input wire [15:0] fl_dq_in,
  output wire [15:0] fl_dq_out,
  output wire fl_dq_oe_n,
  output wire fl_ce_n,
  output wire fl_oe_n,
  output wire fl_we_n
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_ISSUE = 2'd1;
  localparam [1:0] S_WAIT = 2'd2;

  reg [1:0] st_q;
  reg [3:0] step_q;
  reg go_q;
  reg [4:0] op_q;
  reg [25:0] addr_q;
  reg [15:0] wdata_q;
  reg [1:0] count_q;
  reg [15:0] buf_q [0:3];
  reg [2:0] mode_q;
  reg busy_q;
  reg refused_q;
  reg [2:0] pwnext_q;
  reg [15:0] rdata_q;

  wire [15:0] dq_sync;
  wire cyc_done;
  wire [15:0] cyc_rdata;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire acc_wr = psel & penable & pready & pwrite;
  wire is_buf = (paddr[7:4] == 4'h2) && (paddr[1:0] == 2'b00);
  wire hit = (paddr == `FPCD_OFF_CMD) || (paddr == `FPCD_OFF_ADDR) ||
             (paddr == `FPCD_OFF_WDATA) || (paddr == `FPCD_OFF_STATUS) ||
             (paddr == `FPCD_OFF_RDATA) || (paddr == `FPCD_OFF_COUNT) || is_buf;
  wire wr_cmd = acc_wr && (paddr == `FPCD_OFF_CMD);
  wire [4:0] new_op = pwdata[4:0];
  wire [25:0] sector = {addr_q[25:`FPCD_SECTOR_LO], 16'h0000};
  wire prot = (rdata_q[7:0] == `FPCD_PROT_STATE);
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `FPCD_OFF_CMD: rd_mux = {27'h0000000, op_q};
      `FPCD_OFF_ADDR: rd_mux = {6'h00, addr_q};
      `FPCD_OFF_WDATA: rd_mux = {16'h0000, wdata_q};
      `FPCD_OFF_STATUS: rd_mux = {23'h000000, pwnext_q, mode_q, 1'b0, refused_q, busy_q};
      `FPCD_OFF_RDATA: rd_mux = {15'h0000, prot, rdata_q};
      `FPCD_OFF_COUNT: rd_mux = {30'h00000000, count_q};
      default: rd_mux = is_buf ? {16'h0000, buf_q[paddr[3:2]]} : 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // No wait states: answer registered during setup
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Legality of a new operation in the current mode
  // ----------------------------------------------------------------
  reg legal;

  always @* begin
    legal = 1'b0;
    case (new_op)
      `FPCD_OP_ARR_RD: legal = (mode_q == `FPCD_MODE_ARRAY);
      `FPCD_OP_LOCK_ENT, `FPCD_OP_DYB_ENT, `FPCD_OP_ECC_ENT, `FPCD_OP_LREG_ENT,
      `FPCD_OP_PWD_ENT, `FPCD_OP_BUF_LOAD: legal = (mode_q == `FPCD_MODE_ARRAY);
      `FPCD_OP_LOCK_CLR, `FPCD_OP_LOCK_RD: legal = (mode_q == `FPCD_MODE_LOCK);
      `FPCD_OP_DYB_SET, `FPCD_OP_DYB_CLR, `FPCD_OP_DYB_RD:
        legal = (mode_q == `FPCD_MODE_DYB);
      `FPCD_OP_ECC_RD: legal = (mode_q == `FPCD_MODE_ECC);
      `FPCD_OP_EXIT: legal = (mode_q != `FPCD_MODE_ARRAY) && (mode_q != `FPCD_MODE_ECC);
      `FPCD_OP_RESET, `FPCD_OP_ABORT_RST: legal = 1'b1;
      `FPCD_OP_LREG_PRG:
        // Both mode lock bits programmed together would abort in the device
        legal = (mode_q == `FPCD_MODE_LREG) &&
                (wdata_q[`FPCD_LREG_PERSIST_BIT] || wdata_q[`FPCD_LREG_PASSWD_BIT]);
      `FPCD_OP_LREG_RD: legal = (mode_q == `FPCD_MODE_LREG);
      `FPCD_OP_PWD_PRG:
        legal = (mode_q == `FPCD_MODE_PWD) && (pwnext_q[2] == 1'b0) &&
                (addr_q[1:0] == pwnext_q[1:0]);
      `FPCD_OP_PWD_RD: legal = (mode_q == `FPCD_MODE_PWD);
      default: legal = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Step table: address, data and direction of each bus cycle
  // ----------------------------------------------------------------
  reg [25:0] s_addr;
  reg [15:0] s_data;
  reg s_rd;
  reg s_last;
  wire [3:0] bidx = step_q - 4'd4;
  wire unlock_op = (op_q == `FPCD_OP_LOCK_ENT) || (op_q == `FPCD_OP_DYB_ENT) ||
                   (op_q == `FPCD_OP_ECC_ENT) || (op_q == `FPCD_OP_LREG_ENT) ||
                   (op_q == `FPCD_OP_PWD_ENT) || (op_q == `FPCD_OP_BUF_LOAD) ||
                   (op_q == `FPCD_OP_ABORT_RST);

  always @*
  begin
    // Upper data byte stays zero in command cycles; high address lines too, except buffer load and volatile overlay set/clear cycles at the sector
    s_addr = 26'h0000000;
    s_data = 16'h0000;
    s_rd = 1'b0;
    s_last = 1'b0;
    if (unlock_op && step_q == 4'd0) begin
      s_addr = `FPCD_UNLOCK_A1;
      s_data = `FPCD_UNLOCK_D1;
    end else if (unlock_op && step_q == 4'd1) begin
      s_addr = `FPCD_UNLOCK_A2;
      s_data = `FPCD_UNLOCK_D2;
    end else begin
      case (op_q)
        `FPCD_OP_ARR_RD, `FPCD_OP_ECC_RD, `FPCD_OP_PWD_RD: begin
          s_addr = addr_q;
          s_rd = 1'b1;
          s_last = 1'b1;
        end
        `FPCD_OP_LOCK_RD, `FPCD_OP_LREG_RD: begin
          s_rd = 1'b1;
          s_last = 1'b1;
        end
        `FPCD_OP_DYB_RD: begin
          s_addr = sector;
          s_rd = 1'b1;
          s_last = 1'b1;
        end
        `FPCD_OP_LOCK_ENT: begin
          s_addr = `FPCD_UNLOCK_A1;
          s_data = `FPCD_CMD_LOCK_ENT;
          s_last = 1'b1;
        end
        `FPCD_OP_DYB_ENT: begin
          s_addr = `FPCD_UNLOCK_A1;
          s_data = `FPCD_CMD_DYB_ENT;
          s_last = 1'b1;
        end
        `FPCD_OP_ECC_ENT: begin
          s_addr = `FPCD_UNLOCK_A1;
          s_data = `FPCD_CMD_ECC_ENT;
          s_last = 1'b1;
        end
        `FPCD_OP_LREG_ENT: begin
          s_addr = `FPCD_UNLOCK_A1;
          s_data = `FPCD_CMD_LREG_ENT;
          s_last = 1'b1;
        end
        `FPCD_OP_PWD_ENT: begin
          s_addr = `FPCD_UNLOCK_A1;
          s_data = `FPCD_CMD_PWD_ENT;
          s_last = 1'b1;
        end
        `FPCD_OP_ABORT_RST: begin
          s_addr = `FPCD_UNLOCK_A1;
          s_data = `FPCD_CMD_RESET;
          s_last = 1'b1;
        end
        `FPCD_OP_LOCK_CLR: begin
          s_data = (step_q == 4'd0) ? `FPCD_CMD_PROG : 16'h0000;
          s_last = (step_q == 4'd1);
        end
        `FPCD_OP_DYB_SET, `FPCD_OP_DYB_CLR: begin
          // Any word inside the sector selects it
          s_addr = (step_q == 4'd0) ? 26'h0000000 : sector;
          s_data = (step_q == 4'd0) ? `FPCD_CMD_PROG :
                   ((op_q == `FPCD_OP_DYB_CLR) ? 16'h0001 : 16'h0000);
          s_last = (step_q == 4'd1);
        end
        `FPCD_OP_EXIT: begin
          s_data = (step_q == 4'd0) ? `FPCD_CMD_EXIT : 16'h0000;
          s_last = (step_q == 4'd1);
        end
        `FPCD_OP_RESET: begin
          s_data = `FPCD_CMD_RESET;
          s_last = 1'b1;
        end
        `FPCD_OP_LREG_PRG: begin
          s_data = (step_q == 4'd0) ? `FPCD_CMD_PROG : wdata_q;
          s_last = (step_q == 4'd1);
        end
        `FPCD_OP_PWD_PRG: begin
          s_addr = (step_q == 4'd0) ? 26'h0000000 : {24'h000000, addr_q[1:0]};
          s_data = (step_q == 4'd0) ? `FPCD_CMD_PROG : wdata_q;
          s_last = (step_q == 4'd1);
        end
        `FPCD_OP_BUF_LOAD: begin
          s_addr = sector;
          if (step_q == 4'd2) begin
            s_data = `FPCD_CMD_BUF_LOAD;
          end else if (step_q == 4'd3) begin
            s_data = {14'h0000, count_q};
          end else if (bidx <= {2'b00, count_q}) begin
            // Locations differ only in the two low bits, so share one line
            s_addr = {addr_q[25:2], bidx[1:0]};
            s_data = buf_q[bidx[1:0]];
          end else begin
            s_data = `FPCD_CMD_BUF_CONF;
            s_last = 1'b1;
          end
        end
        default: s_last = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers, mode tracking and sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      step_q <= 4'h0;
      go_q <= 1'b0;
      op_q <= 5'h00;
      addr_q <= 26'h0000000;
      wdata_q <= 16'h0000;
      count_q <= 2'b00;
      buf_q[0] <= 16'h0000;
      buf_q[1] <= 16'h0000;
      buf_q[2] <= 16'h0000;
      buf_q[3] <= 16'h0000;
      mode_q <= `FPCD_MODE_ARRAY;
      busy_q <= 1'b0;
      refused_q <= 1'b0;
      pwnext_q <= 3'h0;
      rdata_q <= 16'h0000;
    end else begin
      go_q <= 1'b0;
      if (acc_wr && paddr == `FPCD_OFF_ADDR) addr_q <= pwdata[25:0];
      if (acc_wr && paddr == `FPCD_OFF_WDATA) wdata_q <= pwdata[15:0];
      if (acc_wr && paddr == `FPCD_OFF_COUNT) count_q <= pwdata[1:0];
      if (acc_wr && is_buf) buf_q[paddr[3:2]] <= pwdata[15:0];
      // A refusal in the same cycle as the clear keeps the flag set
      if (wr_cmd && (busy_q || !legal)) begin
        refused_q <= 1'b1;
      end else if (acc_wr && paddr == `FPCD_OFF_STATUS && pwdata[`FPCD_ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          if (wr_cmd && !busy_q && legal) begin
            op_q <= new_op;
            busy_q <= 1'b1;
            step_q <= 4'h0;
            go_q <= 1'b1;
            st_q <= S_ISSUE;
            case (new_op)
              `FPCD_OP_LOCK_ENT: mode_q <= `FPCD_MODE_LOCK;
              `FPCD_OP_DYB_ENT: mode_q <= `FPCD_MODE_DYB;
              `FPCD_OP_ECC_ENT: mode_q <= `FPCD_MODE_ECC;
              `FPCD_OP_LREG_ENT: mode_q <= `FPCD_MODE_LREG;
              `FPCD_OP_PWD_ENT: begin
                mode_q <= `FPCD_MODE_PWD;
                pwnext_q <= 3'h0;
              end
              `FPCD_OP_PWD_PRG: pwnext_q <= pwnext_q + 3'h1;
              `FPCD_OP_EXIT, `FPCD_OP_RESET, `FPCD_OP_ABORT_RST:
                mode_q <= `FPCD_MODE_ARRAY;
              default: mode_q <= mode_q;
            endcase
          end
        end
        S_ISSUE: st_q <= S_WAIT;
        S_WAIT: begin
          if (cyc_done) begin
            if (s_rd) rdata_q <= cyc_rdata;
            if (s_last) begin
              busy_q <= 1'b0;
              st_q <= S_IDLE;
            end else begin
              step_q <= step_q + 4'h1;
              go_q <= 1'b1;
              st_q <= S_ISSUE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin side
  // ----------------------------------------------------------------
  fpcd_sync #(
    .W(16)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(fl_dq_in),
    .q(dq_sync)
  );

  fpcd_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .go(go_q),
    .rd(s_rd),
    .a(s_addr),
    .d(s_data),
    .dq_in(dq_sync),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );
endmodule // fpcd_host

/* File: verif/fpcd_host_properties.sv */
// Checker of the host's APB handshake and flash strobe timing.
// Assumes it is bound to fpcd_host and sees only its ports.
`timescale 1ns/1ps
// ----------------------------------------
// Properties
// ----------------------------------------
module fpcd_host_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [25:0] fl_addr,
  input wire fl_dq_oe_n,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr;
    !fl_we_n [*5] ##1 fl_we_n;
  endsequence
  // Read strobe covers access time plus two synchroniser stages
  sequence s_rd;
    !fl_oe_n [*8] ##1 !fl_oe_n [*8] ##1 fl_oe_n;
  endsequence
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no pready");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("lone pslverr");
  AST_WR_PULSE: assert property ($fell(fl_we_n) |-> s_wr)
    else $error("write strobe width");
  AST_RD_PULSE: assert property ($fell(fl_oe_n) |-> s_rd)
    else $error("read strobe width");
  AST_WR_DRIVE: assert property (!fl_we_n |-> !fl_ce_n && !fl_dq_oe_n && fl_oe_n)
    else $error("write not driven");
  AST_RD_FLOAT: assert property (!fl_oe_n |-> !fl_ce_n && fl_dq_oe_n && fl_we_n)
    else $error("read while driving");
  AST_ADDR_HELD: assert property ($fell(fl_we_n) |-> $stable(fl_addr) [*5])
    else $error("address moved");
  AST_CE_GAP: assert property ($rose(fl_ce_n) |-> fl_ce_n [*2])
    else $error("select gap short");
endmodule // fpcd_host_props

bind fpcd_host fpcd_host_props fpcd_host_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
  .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n)
);

/* File: verif/fpcd_flash_model.sv */
// Behavioural flash decoding the protection command sets.
// Assumes writes are taken at the rising write strobe.
`timescale 1ns/1ps
// ----------------------------------------
// Flash model
// ----------------------------------------
module fpcd_flash_model (
  input wire [25:0] fl_addr,
  input wire [15:0] fl_dq_out,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  output wire [15:0] fl_dq_in
);
  reg [2:0] mode_q = 3'h0;
  reg [37:0] hist_q = 38'h0;
  reg prog_q = 1'b0;
  reg exit_q = 1'b0;
  reg lock_q = 1'b1;
  reg [1023:0] prot_q = 1024'h0;
  reg [15:0] lreg_q = 16'hffff;
  reg [63:0] pwd_q = 64'hffffffffffffffff;
  reg [15:0] rd_q = 16'h0;
  wire [7:0] d = fl_dq_out[7:0];
  wire [10:0] a = fl_addr[10:0];
  wire [9:0] sect = fl_addr[25:16];
  wire unl = hist_q == {11'h555, 8'haa, 11'h2aa, 8'h55};
  always @(posedge fl_we_n) begin
    if (!fl_ce_n) begin
      if (d == 8'hf0 || (exit_q && d == 8'h00)) mode_q <= 3'h0;
      else if (prog_q && mode_q == 3'h1) lock_q <= 1'b0;
      else if (prog_q && mode_q == 3'h2) prot_q[sect] <= !fl_dq_out[0];
      else if (prog_q && mode_q == 3'h4 && !(d[1] | d[2])) mode_q <= 3'h0;
      else if (prog_q && mode_q == 3'h4) lreg_q <= lreg_q & fl_dq_out;
      else if (prog_q && mode_q == 3'h5) pwd_q[16 * a[1:0] +: 16] <= fl_dq_out;
      // No erase ever runs here, so suspend and resume both fall on deaf ears
      else if (d == 8'hb0 || d == 8'h30) mode_q <= mode_q;
      else if (unl && a == 11'h555 && mode_q == 3'h0)
        mode_q <= d == 8'h50 ? 3'h1 : d == 8'he0 ? 3'h2 : d == 8'h75 ? 3'h3 :
          d == 8'h40 ? 3'h4 : d == 8'h60 ? 3'h5 : 3'h0;
      prog_q <= !prog_q && d == 8'ha0 && mode_q != 3'h0;
      exit_q <= !prog_q && d == 8'h90 && mode_q != 3'h0;
      hist_q <= {hist_q[18:0], a, d};
    end
  end
  always @(negedge fl_oe_n) begin
    rd_q <= mode_q == 3'h1 ? {15'h0, !lock_q} :
      mode_q == 3'h2 ? {15'h0, !prot_q[sect]} :
      mode_q == 3'h3 ? 16'h00fe : mode_q == 3'h4 ? lreg_q :
      mode_q == 3'h5 ? pwd_q[16 * fl_addr[1:0] +: 16] :
      fl_addr[15:0] ^ 16'h5a5a;
  end
  // Released pins show the inverse word so a stale value never matches
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd_q : ~rd_q;
endmodule // fpcd_flash_model

/* File: verif/tb.sv */
// Self-checking bench of the flash protection host.
// Assumes the flash model stands on the pins and APB is driven here.
`timescale 1ns/1ps
`include "fpcd_map.vh"
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
  typedef struct {logic [4:0] op; logic [25:0] a; logic [3:0] ms; logic [16:0] rd;} fpcd_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire [25:0] fl_addr;
  wire [15:0] fl_dq_in, fl_dq_out;
  wire pready, pslverr, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] r;
  logic e;
  // Address doubles as write data; status is {refused, mode}
  fpcd_row_t rows [29] = '{
    '{5'h00,26'h12345,4'h0,17'h0791f}, '{5'h01,26'h0,4'h1,17'h0},
    '{5'h03,26'h0,4'h1,17'h10000}, '{5'h02,26'h0,4'h1,17'h0},
    '{5'h03,26'h0,4'h1,17'h00001}, '{5'h0a,26'h0,4'h0,17'h0},
    '{5'h04,26'h0,4'h2,17'h0}, '{5'h05,26'h317ff0,4'h2,17'h0},
    '{5'h07,26'h310000,4'h2,17'h10000}, '{5'h06,26'h31abcd,4'h2,17'h0},
    '{5'h07,26'h310000,4'h2,17'h00001}, '{5'h01,26'h0,4'ha,17'h0},
    '{5'h0b,26'h0,4'h0,17'h0}, '{5'h08,26'h0,4'h3,17'h0},
    '{5'h09,26'h12345,4'h3,17'h000fe}, '{5'h0b,26'h0,4'h0,17'h0},
    '{5'h0c,26'h0,4'h4,17'h0}, '{5'h0d,26'hfff9,4'hc,17'h0},
    '{5'h0d,26'hfffd,4'h4,17'h0}, '{5'h0e,26'h0,4'h4,17'h0fffd},
    '{5'h0a,26'h0,4'h0,17'h0}, '{5'h0f,26'h0,4'h5,17'h0},
    '{5'h10,26'h1,4'hd,17'h0}, '{5'h10,26'h0,4'h5,17'h0},
    '{5'h11,26'h1,4'h5,17'h0ffff}, '{5'h11,26'h0,4'h5,17'h10000},
    '{5'h10,26'h0,4'hd,17'h0},
    '{5'h13,26'h0,4'h0,17'h0}, '{5'h12,26'h0,4'h0,17'h0}};
  fpcd_host fpcd_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
  fpcd_flash_model fpcd_flash_model_i (
    .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in));
  initial begin
    forever #4 pclk = ~pclk;
  end
  task end_sim;
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      end_sim;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Issues one operation and polls until the sequencer is idle
  task run(input logic [4:0] op, input logic [25:0] a);
    int n;
    apb(1'b1, `FPCD_OFF_ADDR, {6'h0, a});
    apb(1'b1, `FPCD_OFF_WDATA, {16'h0, a[15:0]});
    apb(1'b1, `FPCD_OFF_CMD, {27'h0, op});
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 300) begin
      apb(1'b0, `FPCD_OFF_STATUS, 32'h0);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      end_sim;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a);
      chk("status", {28'h0, rows[i].ms}, {28'h0, r[1], r[5:3]});
      if (rows[i].rd !== 17'h0) begin
        apb(1'b0, `FPCD_OFF_RDATA, 32'h0);
        chk("rdata", {15'h0, rows[i].rd}, {15'h0, r[16:0]});
      end
      apb(1'b1, `FPCD_OFF_STATUS, 32'h2);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], e});
    run(5'h00, 26'h0);
    apb(1'b1, `FPCD_OFF_CMD, 32'h0);
    run(5'h00, 26'h0);
    chk("busy refusal", 32'h1, {31'h0, r[1]});
    apb(1'b1, `FPCD_OFF_CMD, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("reset pins", 32'hf, {28'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FPCD_OFF_STATUS, 32'h0);
    chk("reset status", 32'h0, {23'h0, r[8:0]});
    end_sim;
  end
endmodule // tb
